/* include/mrd_pkg.sv */
// Package for the memory map remap decoder: map constants and bus types.
package mrd_pkg;
	localparam logic [31:0] REMAP_LIMIT = 32'h0000_7800;
	localparam logic [31:0] SRAM_BASE = 32'h0004_0000;
	localparam logic [31:0] SRAM_BYTES = 32'h0000_1000;
	localparam logic [31:0] NVM_BASE = 32'h0008_0000;
	localparam logic [31:0] NVM_BYTES = 32'h0000_8000;
	localparam logic [31:0] NVM_USER_BYTES = 32'h0000_7800;
	localparam logic [31:0] PERIPH_BASE = 32'hFFFF_F000;
	localparam logic [31:0] REMAP_CTRL_ADDR = 32'hFFFF_0220;
	localparam int REMAP_BIT = 0;
	localparam logic [7:0] REMAP_CTRL_RESET = 8'h00;
	localparam logic [31:0] VEC_RESET = 32'h0000_0000;
	localparam logic [31:0] VEC_UNDEF = 32'h0000_0004;
	localparam logic [31:0] VEC_SWTRAP = 32'h0000_0008;
	localparam logic [31:0] VEC_PABORT = 32'h0000_000C;
	localparam logic [31:0] VEC_DABORT = 32'h0000_0010;
	localparam logic [31:0] VEC_SIGNATURE = 32'h0000_0014;
	localparam logic [31:0] VEC_IRQ = 32'h0000_0018;
	localparam logic [31:0] VEC_FAST_IRQ = 32'h0000_001C;
	localparam logic [31:0] BOOT_SIGNATURE = 32'h2701_1970;

	typedef enum logic [2:0] {
		MRD_TGT_NONE = 3'h0,
		MRD_TGT_SRAM = 3'h1,
		MRD_TGT_NVM = 3'h2,
		MRD_TGT_PERIPH = 3'h3,
		MRD_TGT_REMAP = 3'h4
	} mrd_target_e;

	typedef enum logic [1:0] {
		MRD_SIZE_BYTE = 2'h0,
		MRD_SIZE_HALF = 2'h1,
		MRD_SIZE_WORD = 2'h2
	} mrd_size_e;

	typedef struct packed {
		logic valid;
		logic write;
		logic fetch;
		mrd_size_e size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} mrd_req_s;

	typedef struct packed {
		logic reset;
		logic dabort;
		logic fast_irq;
		logic irq;
		logic pabort;
		logic sw_trap;
		logic undef;
	} mrd_exc_s;
endpackage : mrd_pkg

/* rtl/mrd_decoder.sv */
// Address decoder, remap control, SRAM and exception vector selection.
//
// Overview of operation
// - Lowest 30 kB decode to SRAM or program memory per remap bit.
// - Top 4 kB of address space is the peripheral register region.
// - SRAM of 1024 words of 32 bits sits at 0x00040000.
// - Program memory is 32 kB: 30 kB user, top 2 kB kernel.
// - Access outside every defined region raises a data abort.
// - Multi-byte data is little endian, low byte at low address.
// - SRAM takes 8, 16, 32-bit reads and writes, fetch at full speed.
// - Remap bit 0 set puts SRAM at zero, cleared puts program memory.
// - Every reset clears the remap bit.
// - Remap control register is 8-bit read/write at 0xFFFF0220.
// - Exception vectors and priority: reset, dabort, fast, irq, pabort.
// - Software trap and undefined share lowest priority, never together.
// - Word 0x14 holds signature or checksum, else download mode; here only the signature is compared, into boot_sig_ok.
// - After reset execution starts in kernel, then branches to zero.
`timescale 1ns/1ps
module mrd_decoder #(
	parameter int SRAM_WORDS = 1024
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire mrd_pkg::mrd_req_s req,
	output logic [31:0] rdata,
	output logic data_abort,
	output logic kernel_select,
	output logic remap_active,
	output mrd_pkg::mrd_target_e target,
	output logic [31:0] nvm_addr,
	input wire logic [31:0] nvm_rdata,
	output logic [31:0] periph_addr,
	output logic periph_valid,
	input wire logic [31:0] periph_rdata,
	input wire mrd_pkg::mrd_exc_s exc_req,
	output logic exc_take,
	output logic [31:0] exc_vector,
	output logic boot_sig_ok
);
	// The index slice below is fixed at ten bits, so only the full 4 kB
	// array decodes correctly; any other depth is refused at elaboration.
	if (SRAM_WORDS != 1024) begin : g_bad_depth
		$error("SRAM_WORDS must be 1024 to fill the SRAM region.");
	end

	logic [7:0] remap_ctrl_q;
	wire [31:0] sram_word;
	logic kernel_q;
	logic [31:0] rdata_q;
	logic data_abort_q;
	logic exc_take_q;
	logic [31:0] exc_vector_q;
	logic boot_sig_ok_q;

	function automatic logic in_range(input logic [31:0] a,
		input logic [31:0] base, input logic [31:0] bytes);
		in_range = (a >= base) && ((a - base) < bytes);
	endfunction : in_range

	// Byte-lane enables for a little endian sub-word access.
	function automatic logic [3:0] lanes(input mrd_pkg::mrd_size_e sz,
		input logic [1:0] a);
		unique case (sz)
			mrd_pkg::MRD_SIZE_BYTE: lanes = 4'h1 << a;
			mrd_pkg::MRD_SIZE_HALF: lanes = a[1] ? 4'hC : 4'h3;
			default: lanes = 4'hF;
		endcase
	endfunction : lanes

	// Remap only redirects the low window. The absolute SRAM and program
	// memory ranges decode the same either way, which is what lets code
	// that flips the bit keep running from its absolute address.
	wire remap_on = remap_ctrl_q[mrd_pkg::REMAP_BIT];
	wire a = req.valid;
	wire in_low = req.addr < mrd_pkg::REMAP_LIMIT;
	wire in_sram = in_range(req.addr, mrd_pkg::SRAM_BASE,
		mrd_pkg::SRAM_BYTES);
	// The kernel's 2 kB stay inside the program memory region; the hidden
	// kernel itself is fenced off by the memory macro, not here.
	wire in_nvm = in_range(req.addr, mrd_pkg::NVM_BASE,
		mrd_pkg::NVM_BYTES);
	wire in_periph = req.addr >= mrd_pkg::PERIPH_BASE;
	wire is_remap_reg = (req.addr[31:2] == mrd_pkg::REMAP_CTRL_ADDR[31:2]);
	// A misaligned half or word access is aborted and writes nothing.
	wire misaligned = (req.size == mrd_pkg::MRD_SIZE_WORD &&
		req.addr[1:0] != 2'h0) ||
		(req.size == mrd_pkg::MRD_SIZE_HALF && req.addr[0]);
	wire low_sram = in_low && remap_on;
	wire low_nvm = in_low && !remap_on;
	wire hit_sram = in_sram || low_sram;
	wire hit_nvm = in_nvm || low_nvm;
	wire defined = in_low || in_sram || in_nvm || in_periph || is_remap_reg;
	wire abort_now = a && (!defined || misaligned);

	// The remap register is tested first: its address lies outside the
	// top 4 kB and would otherwise fall through as undefined.
	assign target = !a ? mrd_pkg::MRD_TGT_NONE :
		is_remap_reg ? mrd_pkg::MRD_TGT_REMAP :
		hit_sram ? mrd_pkg::MRD_TGT_SRAM :
		hit_nvm ? mrd_pkg::MRD_TGT_NVM :
		in_periph ? mrd_pkg::MRD_TGT_PERIPH : mrd_pkg::MRD_TGT_NONE;

	// Low alias wraps modulo the memory size.
	wire [9:0] sram_idx = req.addr[11:2];
	assign nvm_addr = mrd_pkg::NVM_BASE | {17'h0, req.addr[14:0]};
	assign periph_addr = req.addr;
	// A misaligned access never reaches a peripheral, since its lanes
	// would mean nothing there.
	assign periph_valid = a && in_periph && !is_remap_reg && !misaligned;
	assign remap_active = remap_on;
	assign kernel_select = kernel_q;

	wire [3:0] be = lanes(req.size, req.addr[1:0]);
	// Write data is replicated so byte n lands on lane n.
	wire [31:0] wrep = (req.size == mrd_pkg::MRD_SIZE_BYTE) ?
		{4{req.wdata[7:0]}} :
		(req.size == mrd_pkg::MRD_SIZE_HALF) ?
		{2{req.wdata[15:0]}} : req.wdata;
	wire sram_we = a && req.write && hit_sram && !misaligned && !is_remap_reg;

	// One byte-wide array per lane, so that every array has a single
	// writing process; a shared word array written lane by lane from four
	// processes would have four drivers.
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			logic [7:0] lane_mem [SRAM_WORDS];
			always_ff @(posedge ref_clk) begin
				if (sram_we && be[g]) begin
					lane_mem[sram_idx] <= wrep[8*g +: 8];
				end
			end
			assign sram_word[8*g +: 8] = lane_mem[sram_idx];
		end
	endgenerate

	// Reserved bits are stored as written; software keeps them zero.
	// A write lands at the taking edge, so the very next request already
	// sees the new map.
	wire remap_wr = a && req.write && is_remap_reg && !misaligned && be[0];
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			remap_ctrl_q <= mrd_pkg::REMAP_CTRL_RESET;
		end else if (remap_wr) begin
			remap_ctrl_q <= wrep[7:0];
		end
	end

	// The hidden kernel runs first after every reset. Its first fetch of
	// the reset vector hands control to user code; the flag does not come
	// back until the next reset.
	wire kernel_exit = a && req.fetch && !req.write &&
		req.addr == mrd_pkg::VEC_RESET;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			kernel_q <= 1'b1;
		end else if (kernel_exit) begin
			kernel_q <= 1'b0;
		end
	end

	// Read data is one cycle after the request, right-justified.
	wire [31:0] raw = hit_sram ? sram_word :
		hit_nvm ? nvm_rdata :
		is_remap_reg ? {24'h0, remap_ctrl_q} :
		in_periph ? periph_rdata : 32'h0;
	wire [31:0] shifted = raw >> {req.addr[1:0], 3'h0};
	wire [31:0] rd_d = (req.size == mrd_pkg::MRD_SIZE_BYTE) ?
		{24'h0, shifted[7:0]} :
		(req.size == mrd_pkg::MRD_SIZE_HALF) ?
		{16'h0, shifted[15:0]} : raw;

	// SRAM keeps its contents across reset; only the map, the kernel flag
	// and the answer registers return to their idle values.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rdata_q <= 32'h0;
			data_abort_q <= 1'b0;
		end else begin
			rdata_q <= (a && !req.write && !abort_now) ? rd_d : 32'h0;
			data_abort_q <= abort_now;
		end
	end

	// Fixed priority; software trap and undefined are exclusive.
	wire [31:0] vec_d = exc_req.reset ? mrd_pkg::VEC_RESET :
		exc_req.dabort ? mrd_pkg::VEC_DABORT :
		exc_req.fast_irq ? mrd_pkg::VEC_FAST_IRQ :
		exc_req.irq ? mrd_pkg::VEC_IRQ :
		exc_req.pabort ? mrd_pkg::VEC_PABORT :
		exc_req.sw_trap ? mrd_pkg::VEC_SWTRAP : mrd_pkg::VEC_UNDEF;
	wire any_exc = |exc_req;

	// Signature check on the word read at vector 0x14 from program memory.
	wire sig_read = a && !req.write && low_nvm &&
		req.addr == mrd_pkg::VEC_SIGNATURE;

	// The vector register holds its last value between exceptions, so a
	// late reader still sees which one was taken.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			exc_take_q <= 1'b0;
			exc_vector_q <= mrd_pkg::VEC_RESET;
			boot_sig_ok_q <= 1'b0;
		end else begin
			exc_take_q <= any_exc;
			if (any_exc) begin
				exc_vector_q <= vec_d;
			end
			if (sig_read) begin
				boot_sig_ok_q <= nvm_rdata == mrd_pkg::BOOT_SIGNATURE;
			end
		end
	end

	assign rdata = rdata_q;
	assign data_abort = data_abort_q;
	assign exc_take = exc_take_q;
	assign exc_vector = exc_vector_q;
	assign boot_sig_ok = boot_sig_ok_q;
endmodule : mrd_decoder

/* verif/mrd_decoder_checker.sv */
// Concurrent checks on the decoder ports.
`timescale 1ns/1ps
module mrd_decoder_checker (
	input wire logic ref_clk,
	input wire logic srst,
	input wire mrd_pkg::mrd_req_s req,
	input wire logic [31:0] rdata,
	input wire logic data_abort,
	input wire logic remap_active,
	input wire logic kernel_select,
	input wire logic periph_valid,
	input wire mrd_pkg::mrd_target_e target,
	input wire mrd_pkg::mrd_exc_s exc_req,
	input wire logic [31:0] exc_vector
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	wire low = req.valid && req.addr < mrd_pkg::REMAP_LIMIT;
	sequence s_remap_wr;
		req.valid && req.write && req.addr == mrd_pkg::REMAP_CTRL_ADDR;
	endsequence
	a_remap_write: assert property (s_remap_wr |=>
		remap_active == $past(req.wdata[0])) else $error("remap bit");
	a_abort_undef: assert property (req.valid &&
		target == mrd_pkg::MRD_TGT_NONE |=> data_abort) else $error("abort");
	a_abort_zero: assert property (data_abort |-> rdata == '0)
		else $error("abort data");
	a_low_sram: assert property (low && remap_active |->
		target == mrd_pkg::MRD_TGT_SRAM) else $error("low sram");
	a_low_nvm: assert property (low && !remap_active |->
		target == mrd_pkg::MRD_TGT_NVM) else $error("low nvm");
	a_sram_abs: assert property (req.valid &&
		req.addr[31:12] == 20'h00040 |-> target == mrd_pkg::MRD_TGT_SRAM)
		else $error("sram decode");
	a_periph_top: assert property (req.valid && &req.addr[31:12] |->
		target == mrd_pkg::MRD_TGT_PERIPH) else $error("periph decode");
	a_reset_remap: assert property ($fell(srst) |-> !remap_active)
		else $error("remap after reset");
	a_fast_vec: assert property (exc_req.fast_irq && !exc_req.reset &&
		!exc_req.dabort |=> exc_vector == 32'h1C) else $error("fast vec");
	sequence s_vector_fetch;
		req.valid && req.fetch && !req.write &&
			req.addr == mrd_pkg::VEC_RESET;
	endsequence
	a_kernel_exit: assert property (s_vector_fetch |=> !kernel_select)
		else $error("kernel flag after vector fetch");
	a_kernel_reset: assert property ($fell(srst) |-> kernel_select)
		else $error("kernel flag after reset");
	a_periph_pass: assert property (req.valid &&
		target == mrd_pkg::MRD_TGT_PERIPH &&
		req.size == mrd_pkg::MRD_SIZE_WORD && req.addr[1:0] == 2'h0 |->
		periph_valid) else $error("peripheral strobe");
	a_abort_misalign: assert property (req.valid &&
		req.size == mrd_pkg::MRD_SIZE_WORD && req.addr[1:0] != 2'h0 |=>
		data_abort) else $error("misaligned abort");
endmodule : mrd_decoder_checker

/* verif/mrd_mem_model.sv */
// Program memory and peripheral read data seen by the decoder.
`timescale 1ns/1ps
module mrd_mem_model (
	input wire logic [31:0] nvm_addr,
	output logic [31:0] nvm_rdata,
	input wire logic [31:0] periph_addr,
	output logic [31:0] periph_rdata
);
	// Each word except the signature word at 0x14 carries its own index so a wrong offset shows up.
	wire sig = nvm_addr[14:2] == 13'h5;
	assign nvm_rdata = sig ? mrd_pkg::BOOT_SIGNATURE :
		{16'hC3A5, 3'h0, nvm_addr[14:2], 2'h0};
	assign periph_rdata = ~periph_addr;
endmodule : mrd_mem_model

/* verif/mrd_decoder_bench.sv */
// Self-checking testbench for the memory map remap decoder.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
	n_fail++; $display("unexpected at %0t: mismatch", $time); end end
module mrd_decoder_bench;
	localparam logic [1:0] B = 2'h0, H = 2'h1, W = 2'h2;
	localparam logic [31:0] SB = mrd_pkg::SRAM_BASE, NB = mrd_pkg::NVM_BASE;
	localparam logic [31:0] RA = mrd_pkg::REMAP_CTRL_ADDR;
	logic ref_clk = 0, srst = 1;
	mrd_pkg::mrd_req_s req = '0;
	mrd_pkg::mrd_exc_s exc_req = '0;
	logic [31:0] rdata, nvm_addr, nvm_rdata, periph_addr, periph_rdata;
	logic [31:0] exc_vector, rd;
	logic data_abort, remap_active, exc_take, boot_sig_ok, ab, kernel_select;
	logic periph_valid;
	mrd_pkg::mrd_target_e target;
	int n_fail = 0, comparisons = 0;
	mrd_decoder i_dut (.ref_clk, .srst, .req, .rdata, .data_abort,
		.kernel_select, .remap_active, .target, .nvm_addr, .nvm_rdata,
		.periph_addr, .periph_valid, .periph_rdata, .exc_req,
		.exc_take, .exc_vector, .boot_sig_ok);
	mrd_mem_model i_mem (.nvm_addr, .nvm_rdata, .periph_addr, .periph_rdata);
	initial forever #10 ref_clk = ~ref_clk;
	task automatic acc(input logic w, input logic [1:0] s,
		input logic [31:0] a, input logic [31:0] d);
		@(posedge ref_clk) req <= '{1'b1, w, 1'b0, mrd_pkg::mrd_size_e'(s), a, d};
		@(posedge ref_clk) req.valid <= 1'b0;
		#1 rd = rdata;
		ab = data_abort;
	endtask : acc
	function automatic logic [31:0] nvm_word(input logic [31:0] a);
		return {16'hC3A5, 3'h0, a[14:2], 2'h0};
	endfunction : nvm_word
	task automatic t_sram;
		acc(1, W, SB + 8, 32'h11223344);
		acc(0, W, SB + 8, 0);
		`CHK(rd, 32'h11223344)
		acc(0, B, SB + 9, 0);
		`CHK(rd, 32'h33)
		acc(0, H, SB + 10, 0);
		`CHK(rd, 32'h1122)
		acc(1, B, SB + 11, 32'hEE);
		acc(0, W, SB + 8, 0);
		`CHK(rd, 32'hEE223344)
		acc(1, W, SB + 32'hFFC, 32'h5A5A0F0F);
		acc(0, W, SB + 32'hFFC, 0);
		`CHK(rd, 32'h5A5A0F0F)
		$display("sram test done");
	endtask : t_sram
	task automatic t_map;
		acc(0, W, NB + 32'h100, 0);
		`CHK(rd, nvm_word(32'h100))
		acc(0, W, 32'h100, 0);
		`CHK(rd, nvm_word(32'h100))
		acc(0, W, 32'h77FC, 0);
		`CHK(ab, 1'b0)
		acc(0, W, 32'h7800, 0);
		`CHK({ab, rd}, {1'b1, 32'h0})
		acc(0, W, 32'h14, 0);
		`CHK(boot_sig_ok, 1'b1)
		acc(1, W, 32'h10000, 32'h1);
		`CHK({ab, rd}, {1'b1, 32'h0})
		acc(0, W, SB + 32'h2, 0);
		`CHK({ab, rd}, {1'b1, 32'h0})
		acc(0, W, 32'hFFFFF010, 0);
		`CHK(rd, ~32'hFFFFF010)
		$display("map test done");
	endtask : t_map
	task automatic t_remap;
		acc(1, W, SB, 32'hCAFE0001);
		acc(1, B, RA, 32'h01);
		`CHK(remap_active, 1'b1)
		acc(0, W, 32'h0, 0);
		`CHK(rd, 32'hCAFE0001)
		acc(0, W, 32'h1000, 0);
		`CHK(rd, 32'hCAFE0001)
		acc(0, W, NB, 0);
		`CHK(rd, nvm_word(0))
		acc(0, B, RA, 0);
		`CHK(rd, 32'h01)
		@(posedge ref_clk) srst <= 1;
		@(posedge ref_clk) srst <= 0;
		#1 `CHK(remap_active, 1'b0)
		`CHK(kernel_select, 1'b1)
		acc(0, W, 32'h0, 0);
		`CHK(rd, nvm_word(0))
		$display("remap test done");
	endtask : t_remap
	task automatic fch(input logic [31:0] a);
		@(posedge ref_clk) req <= '{1'b1, 1'b0, 1'b1,
			mrd_pkg::MRD_SIZE_WORD, a, 32'h0};
		@(posedge ref_clk) req.valid <= 1'b0;
		#1 rd = rdata;
	endtask : fch
	task automatic t_kernel;
		`CHK(kernel_select, 1'b1)
		fch(32'h0);
		`CHK({kernel_select, rd}, {1'b0, nvm_word(32'h0)})
		fch(SB + 32'h8);
		`CHK(rd, 32'hEE223344)
		$display("kernel test done");
	endtask : t_kernel
	task automatic t_exc;
		logic [6:0] m [7] = '{7'h7E, 7'h3E, 7'h1E, 7'h0E, 7'h06, 7'h02, 7'h01};
		logic [31:0] v [7] = '{32'h0, 32'h10, 32'h1C, 32'h18, 32'h0C,
			32'h8, 32'h4};
		for (int k = 0; k < 7; k++) begin
			@(posedge ref_clk) exc_req <= mrd_pkg::mrd_exc_s'(m[k]);
			@(posedge ref_clk) exc_req <= '0;
			#1 `CHK({exc_take, exc_vector}, {1'b1, v[k]})
		end
		$display("exception test done");
	endtask : t_exc
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (3) @(posedge ref_clk);
		srst <= 0;
		t_sram;
		t_kernel;
		t_map;
		t_remap;
		t_exc;
		end_of_test;
	end
	initial begin
		#100000;
		n_fail++;
		end_of_test;
	end
endmodule : mrd_decoder_bench
bind mrd_decoder mrd_decoder_checker i_chk (.ref_clk, .srst, .req, .rdata,
	.data_abort, .remap_active, .kernel_select, .periph_valid, .target,
	.exc_req, .exc_vector);
